// ==== atr_pkg.sv ====
// package: address map and reset values of the alarm threshold register bank
package atr_pkg;
  localparam int unsigned ATR_ADDR_W      = 7;
  localparam int unsigned ATR_DATA_W      = 8;
  localparam int unsigned ATR_THR_W       = 16;
  localparam int unsigned ATR_CHANNELS    = 8;
  // five byte registers per channel
  localparam int unsigned ATR_STRIDE      = 5;
  localparam logic [6:0] ATR_BAND_BASE    = 7'h15;
  localparam logic [6:0] ATR_HIGH_UP_BASE = 7'h16;
  localparam logic [6:0] ATR_HIGH_LO_BASE = 7'h17;
  localparam logic [6:0] ATR_LOW_UP_BASE  = 7'h18;
  localparam logic [6:0] ATR_LOW_LO_BASE  = 7'h19;
  // per-register slot within a channel's group of five
  localparam logic [2:0] ATR_SLOT_BAND    = 3'h0;
  localparam logic [2:0] ATR_SLOT_HIGH_UP = 3'h1;
  localparam logic [2:0] ATR_SLOT_HIGH_LO = 3'h2;
  localparam logic [2:0] ATR_SLOT_LOW_UP  = 3'h3;
  localparam logic [2:0] ATR_SLOT_LOW_LO  = 3'h4;
  localparam logic [7:0] ATR_HIGH_UP_RST  = 8'h01;
  localparam logic [7:0] ATR_HIGH_LO_RST  = 8'h01;
  localparam logic [7:0] ATR_LOW_UP_RST   = 8'h00;
  localparam logic [7:0] ATR_LOW_LO_RST   = 8'h00;
  localparam logic [7:0] ATR_BAND_RST     = 8'h00;
  localparam logic [7:0] ATR_UNMAPPED_RD  = 8'h00;
endpackage : atr_pkg

// ==== atr_chan.sv ====
// one channel's five alarm byte registers
`timescale 1ns/1ps
`default_nettype none
module atr_chan
  import atr_pkg::*;
(
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // write port, channel already decoded; the slot is decoded here
  input  wire logic       wr_en,
  input  wire logic [2:0] wr_slot,
  input  wire logic [7:0] wr_data,
  // stored bytes
  output logic [7:0]      band_r,
  output logic [7:0]      high_up_r,
  output logic [7:0]      high_lo_r,
  output logic [7:0]      low_up_r,
  output logic [7:0]      low_lo_r
);
  // each byte has its own enable so a write leaves the other bytes alone
  always_ff @(posedge clk) begin
    if (rst) begin
      band_r    <= ATR_BAND_RST;
      high_up_r <= ATR_HIGH_UP_RST; // [R7]
      high_lo_r <= ATR_HIGH_LO_RST; // [R7]
      low_up_r  <= ATR_LOW_UP_RST; // [R7]
      low_lo_r  <= ATR_LOW_LO_RST;
    end else if (wr_en) begin // [R9]
      case (wr_slot)
        ATR_SLOT_BAND:    band_r    <= wr_data;
        ATR_SLOT_HIGH_UP: high_up_r <= wr_data; // [R1]
        ATR_SLOT_HIGH_LO: high_lo_r <= wr_data; // [R2]
        ATR_SLOT_LOW_UP:  low_up_r  <= wr_data; // [R3]
        ATR_SLOT_LOW_LO:  low_lo_r  <= wr_data;
        default: ;
      endcase
    end
  end
endmodule : atr_chan
`default_nettype wire

// ==== alarm_threshold_regs.sv ====
// top of the per-channel alarm threshold register bank
//
// Our own choice: strobed register access.
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// [R1] each channel has a read/write high-limit upper byte; channel 0 at 16h
// [R2] each channel has a read/write high-limit lower byte; channel 0 at 17h
// [R3] each channel has a read/write low-limit upper byte; channel 0 at 18h
// [R4] high limit is upper byte above lower byte, sixteen bits
// [R5] low limit is upper byte above lower byte at 19h for channel 0
// [R6] register set repeats per channel, eight or four channels
// [R7] reset loads high bytes with 01h and low upper byte with 00h
// [R8] five registers per channel from 15h, stepping five per channel
// [R9] writing one byte changes only that byte of its threshold
module alarm_threshold_regs
  import atr_pkg::*;
#(
  parameter int unsigned CHANNELS = ATR_CHANNELS
)(
  // clock and reset
  input  wire logic                          clk,
  input  wire logic                          rst,
  // register port
  input  wire logic [ATR_ADDR_W-1:0]         reg_addr,
  input  wire logic [ATR_DATA_W-1:0]         reg_wdata,
  input  wire logic                          reg_wr,
  input  wire logic                          reg_rd,
  output logic [ATR_DATA_W-1:0]              reg_rdata,
  // assembled thresholds and hysteresis band, channel 0 in the low slice
  output logic [CHANNELS*ATR_THR_W-1:0]      channel_high_limit,
  output logic [CHANNELS*ATR_THR_W-1:0]      channel_low_limit,
  output logic [CHANNELS*ATR_DATA_W-1:0]     channel_alarm_band
);
  logic [7:0] band_w    [CHANNELS];
  logic [7:0] high_up_w [CHANNELS];
  logic [7:0] high_lo_w [CHANNELS];
  logic [7:0] low_up_w  [CHANNELS];
  logic [7:0] low_lo_w  [CHANNELS];
  logic [7:0] rd_nxt;

  localparam logic [6:0] LAST_ADDR =
    7'(ATR_BAND_BASE + CHANNELS*ATR_STRIDE - 1);

  genvar g;
  generate
    for (g = 0; g < CHANNELS; g++) begin : g_ch // [R6]
      localparam logic [6:0] BASE = 7'(ATR_BAND_BASE + g*ATR_STRIDE); // [R8]
      logic       hit;
      logic [6:0] off;
      assign off = reg_addr - BASE;
      assign hit = (reg_addr >= BASE) && (off < 7'(ATR_STRIDE));
      atr_chan u_chan (
        .clk       (clk),
        .rst       (rst),
        .wr_en     (reg_wr && hit),
        .wr_slot   (off[2:0]),
        .wr_data   (reg_wdata),
        .band_r    (band_w[g]),
        .high_up_r (high_up_w[g]),
        .high_lo_r (high_lo_w[g]),
        .low_up_r  (low_up_w[g]),
        .low_lo_r  (low_lo_w[g])
      );
      // registered so outputs come from flip-flops; one cycle behind the byte
      always_ff @(posedge clk) begin
        if (rst) begin
          channel_high_limit[g*16 +: 16] <= {ATR_HIGH_UP_RST, ATR_HIGH_LO_RST};
          channel_low_limit[g*16 +: 16]  <= {ATR_LOW_UP_RST, ATR_LOW_LO_RST};
          channel_alarm_band[g*8 +: 8]   <= ATR_BAND_RST;
        end else begin
          channel_high_limit[g*16 +: 16] <= {high_up_w[g], high_lo_w[g]}; // [R4]
          channel_low_limit[g*16 +: 16]  <= {low_up_w[g], low_lo_w[g]}; // [R5]
          channel_alarm_band[g*8 +: 8]   <= band_w[g];
        end
      end

      // per-channel checks; addresses come from the package bases, not BASE
      localparam logic [6:0] A_BAND = 7'(ATR_BAND_BASE + g*ATR_STRIDE);
      localparam logic [6:0] A_HU   = 7'(ATR_HIGH_UP_BASE + g*ATR_STRIDE);
      localparam logic [6:0] A_HL   = 7'(ATR_HIGH_LO_BASE + g*ATR_STRIDE);
      localparam logic [6:0] A_LU   = 7'(ATR_LOW_UP_BASE + g*ATR_STRIDE);
      localparam logic [6:0] A_LL   = 7'(ATR_LOW_LO_BASE + g*ATR_STRIDE);
      AST_CH_RST: assert property (@(posedge clk) // [R7]
        $fell(rst) |-> channel_high_limit[g*16 +: 16] ==
        {ATR_HIGH_UP_RST, ATR_HIGH_LO_RST} &&
        channel_low_limit[g*16 + 8 +: 8] == ATR_LOW_UP_RST)
        else $error("channel reset value wrong");
      AST_CH_WR_HU: assert property (@(posedge clk) disable iff (rst) // [R1]
        reg_wr && reg_addr == A_HU |-> ##2
        channel_high_limit[g*16 + 8 +: 8] == $past(reg_wdata, 2))
        else $error("channel high upper byte not stored");
      AST_CH_WR_HL: assert property (@(posedge clk) disable iff (rst) // [R2]
        reg_wr && reg_addr == A_HL |-> ##2
        channel_high_limit[g*16 +: 8] == $past(reg_wdata, 2))
        else $error("channel high lower byte not stored");
      AST_CH_WR_LU: assert property (@(posedge clk) disable iff (rst) // [R3]
        reg_wr && reg_addr == A_LU |-> ##2
        channel_low_limit[g*16 + 8 +: 8] == $past(reg_wdata, 2))
        else $error("channel low upper byte not stored");
      AST_CH_WR_LL: assert property (@(posedge clk) disable iff (rst) // [R5]
        reg_wr && reg_addr == A_LL |-> ##2
        channel_low_limit[g*16 +: 8] == $past(reg_wdata, 2))
        else $error("channel low lower byte not stored");
      AST_CH_WR_BAND: assert property (@(posedge clk) disable iff (rst) // [R8]
        reg_wr && reg_addr == A_BAND |-> ##2
        channel_alarm_band[g*8 +: 8] == $past(reg_wdata, 2))
        else $error("channel band byte not stored");
      AST_CH_RD_HU: assert property (@(posedge clk) disable iff (rst) // [R1]
        reg_rd && reg_addr == A_HU |=>
        reg_rdata == channel_high_limit[g*16 + 8 +: 8])
        else $error("channel high upper readback differs");
      AST_CH_RD_HL: assert property (@(posedge clk) disable iff (rst) // [R2]
        reg_rd && reg_addr == A_HL |=>
        reg_rdata == channel_high_limit[g*16 +: 8])
        else $error("channel high lower readback differs");
      AST_CH_RD_LU: assert property (@(posedge clk) disable iff (rst) // [R3]
        reg_rd && reg_addr == A_LU |=>
        reg_rdata == channel_low_limit[g*16 + 8 +: 8])
        else $error("channel low upper readback differs");
      AST_CH_RD_LL: assert property (@(posedge clk) disable iff (rst) // [R5]
        reg_rd && reg_addr == A_LL |=>
        reg_rdata == channel_low_limit[g*16 +: 8])
        else $error("channel low lower readback differs");
      AST_CH_RD_BAND: assert property (@(posedge clk) disable iff (rst) // [R8]
        reg_rd && reg_addr == A_BAND |=>
        reg_rdata == channel_alarm_band[g*8 +: 8])
        else $error("channel band readback differs");
      AST_CH_KEEP_HL: assert property (@(posedge clk) disable iff (rst) // [R9]
        reg_wr && reg_addr == A_HU |-> ##2
        channel_high_limit[g*16 +: 8] ==
        $past(channel_high_limit[g*16 +: 8], 1))
        else $error("high upper write disturbed high lower byte");
      AST_CH_KEEP_HU: assert property (@(posedge clk) disable iff (rst) // [R9]
        reg_wr && reg_addr == A_HL |-> ##2
        channel_high_limit[g*16 + 8 +: 8] ==
        $past(channel_high_limit[g*16 + 8 +: 8], 1))
        else $error("high lower write disturbed high upper byte");
      AST_CH_KEEP_LL: assert property (@(posedge clk) disable iff (rst) // [R9]
        reg_wr && reg_addr == A_LU |-> ##2
        channel_low_limit[g*16 +: 8] ==
        $past(channel_low_limit[g*16 +: 8], 1))
        else $error("low upper write disturbed low lower byte");
      AST_CH_KEEP_LU: assert property (@(posedge clk) disable iff (rst) // [R9]
        reg_wr && reg_addr == A_LL |-> ##2
        channel_low_limit[g*16 + 8 +: 8] ==
        $past(channel_low_limit[g*16 + 8 +: 8], 1))
        else $error("low lower write disturbed low upper byte");
    end
  endgenerate

  // read mux; unmapped addresses read zero
  always_comb begin
    logic [6:0] rel;
    rel    = reg_addr - ATR_BAND_BASE;
    rd_nxt = ATR_UNMAPPED_RD;
    for (int c = 0; c < CHANNELS; c++) begin
      if (reg_addr >= ATR_BAND_BASE && reg_addr <= LAST_ADDR &&
          rel >= 7'(c*ATR_STRIDE) && rel < 7'((c+1)*ATR_STRIDE)) begin
        case (3'(rel - 7'(c*ATR_STRIDE)))
          ATR_SLOT_BAND:    rd_nxt = band_w[c];
          ATR_SLOT_HIGH_UP: rd_nxt = high_up_w[c];
          ATR_SLOT_HIGH_LO: rd_nxt = high_lo_w[c];
          ATR_SLOT_LOW_UP:  rd_nxt = low_up_w[c];
          ATR_SLOT_LOW_LO:  rd_nxt = low_lo_w[c];
          default:          rd_nxt = ATR_UNMAPPED_RD;
        endcase
      end
    end
  end

  // read data stands only in the cycle after the read strobe
  always_ff @(posedge clk) begin
    if (rst) begin
      reg_rdata <= ATR_UNMAPPED_RD;
    end else if (reg_rd) begin
      reg_rdata <= rd_nxt;
    end else begin
      reg_rdata <= ATR_UNMAPPED_RD;
    end
  end

  AST_RST_HIGH: assert property (@(posedge clk) // [R7]
    $fell(rst) |-> channel_high_limit[15:0] == 16'h0101
                && channel_low_limit[15:8] == 8'h00)
    else $error("threshold reset values wrong");
  AST_HIGH_UP_WR: assert property (@(posedge clk) disable iff (rst) // [R1]
    reg_wr && reg_addr == ATR_HIGH_UP_BASE ##1 reg_rd &&
    reg_addr == ATR_HIGH_UP_BASE |=> reg_rdata == $past(reg_wdata, 2))
    else $error("high upper byte readback mismatch");
  AST_HIGH_LO_WR: assert property (@(posedge clk) disable iff (rst) // [R2]
    reg_wr && reg_addr == ATR_HIGH_LO_BASE |-> ##2
    channel_high_limit[7:0] == $past(reg_wdata, 2))
    else $error("high lower byte not stored");
  AST_LOW_UP_WR: assert property (@(posedge clk) disable iff (rst) // [R3]
    reg_wr && reg_addr == ATR_LOW_UP_BASE |-> ##2
    channel_low_limit[15:8] == $past(reg_wdata, 2))
    else $error("low upper byte not stored");
  AST_HIGH_CAT: assert property (@(posedge clk) disable iff (rst) // [R4]
    ##1 channel_high_limit[15:0] == {$past(high_up_w[0]), $past(high_lo_w[0])})
    else $error("high limit assembly wrong");
  AST_LOW_CAT: assert property (@(posedge clk) disable iff (rst) // [R5]
    ##1 channel_low_limit[15:0] == {$past(low_up_w[0]), $past(low_lo_w[0])})
    else $error("low limit assembly wrong");
  AST_LAST_CH: assert property (@(posedge clk) disable iff (rst) // [R6]
    reg_wr && reg_addr == LAST_ADDR - 7'h1 |-> ##2
    channel_low_limit[CHANNELS*16-1 -: 8] == $past(reg_wdata, 2))
    else $error("last channel low upper byte not stored");
  AST_STRIDE: assert property (@(posedge clk) disable iff (rst) // [R8]
    reg_wr && reg_addr == 7'h1b |-> ##2
    channel_high_limit[31:24] == $past(reg_wdata, 2))
    else $error("channel 1 high upper byte at wrong address");
  AST_KEEP_OTHER: assert property (@(posedge clk) disable iff (rst) // [R9]
    reg_wr && reg_addr == ATR_HIGH_UP_BASE |-> ##2
    channel_high_limit[7:0] == $past(channel_high_limit[7:0], 1))
    else $error("upper write disturbed lower byte");

  // read port: data only after a strobe, and nothing outside the map
  AST_RD_IDLE: assert property (@(posedge clk) disable iff (rst) // [R8]
    !reg_rd |=> reg_rdata == ATR_UNMAPPED_RD)
    else $error("read data present without a read");
  AST_UNMAPPED: assert property (@(posedge clk) disable iff (rst) // [R8]
    reg_rd && (reg_addr < ATR_BAND_BASE || reg_addr > LAST_ADDR) |=>
    reg_rdata == ATR_UNMAPPED_RD)
    else $error("unmapped address read nonzero");
endmodule : alarm_threshold_regs
`default_nettype wire

// ==== alarm_threshold_regs_tb_top.sv ====
// self-checking testbench of the alarm threshold register bank
`timescale 1ns/1ps
`default_nettype none
module alarm_threshold_regs_tb_top;
  import atr_pkg::*;
  localparam int CH = 8;
  logic             clk = 1'b0;
  logic             rst = 1'b1;
  logic [6:0]       reg_addr = 7'h00;
  logic [7:0]       reg_wdata = 8'h00;
  logic             reg_wr = 1'b0;
  logic             reg_rd = 1'b0;
  logic [7:0]       reg_rdata;
  logic [CH*16-1:0] channel_high_limit;
  logic [CH*16-1:0] channel_low_limit;
  logic [CH*8-1:0]  channel_alarm_band;
  logic [7:0]       shadow [0:127];
  logic [7:0]       exp_q [$];
  logic             rd_q = 1'b0;
  int               mismatches = 0;
  int               num_checks = 0;
  int               cycles = 0;
  int               seed = 32'h3fe2_ee68;
  alarm_threshold_regs #(.CHANNELS(CH)) dut_u (
    .clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .channel_high_limit(channel_high_limit),
    .channel_low_limit(channel_low_limit),
    .channel_alarm_band(channel_alarm_band));
  always #5 clk = ~clk;
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic conclude();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : conclude
  // expected contents of every byte straight after a reset
  task automatic reset_shadow();
    for (int a = 0; a < 128; a++) shadow[a] = 8'h00;
    for (int c = 0; c < CH; c++) begin
      shadow[7'h15+5*c] = ATR_BAND_RST;
      shadow[7'h16+5*c] = ATR_HIGH_UP_RST;
      shadow[7'h17+5*c] = ATR_HIGH_LO_RST;
      shadow[7'h18+5*c] = ATR_LOW_UP_RST;
      shadow[7'h19+5*c] = ATR_LOW_LO_RST;
    end
  endtask : reset_shadow
  // one bus cycle; strobes may follow each other with no gap
  task automatic op(input logic w, input logic r, input logic [6:0] a,
                    input logic [7:0] d);
    @(posedge clk);
    reg_wr    <= w;
    reg_rd    <= r;
    reg_addr  <= a;
    reg_wdata <= d;
    if (w && a >= 7'h15 && a < 7'h15 + 5 * CH) shadow[a] = d;
    if (r) exp_q.push_back(shadow[a]);
  endtask : op
  // limit outputs lag the byte registers, so let three edges pass first
  task automatic check_limits();
    repeat (3) @(posedge clk);
    #1;
    for (int c = 0; c < CH; c++) begin
      check(channel_high_limit[16*c+:16], {shadow[7'h16+5*c], shadow[7'h17+5*c]});
      check(channel_low_limit[16*c+:16], {shadow[7'h18+5*c], shadow[7'h19+5*c]});
      check({8'h00, channel_alarm_band[8*c+:8]}, {8'h00, shadow[7'h15+5*c]});
    end
  endtask : check_limits
  // read data stands only in the cycle after the read strobe
  always @(posedge clk) begin
    rd_q <= reg_rd;
    if (rd_q) begin
      if (exp_q.size() == 0) check(16'hffff, 16'h0000);
      else check({8'h00, reg_rdata}, {8'h00, exp_q.pop_front()});
    end
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 6000) begin
      mismatches++;
      conclude();
    end
  end
  initial begin
    reset_shadow();
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    // reset values of every channel, one address either side unmapped
    for (int a = 7'h14; a <= 7'h3d; a++) op(0, 1, a[6:0], 8'h00);
    op(0, 0, 7'h00, 8'h00);
    check_limits();
    // random bytes over 10h to 42h and ffh at 7fh, including unmapped places that must ignore them
    for (int a = 7'h10; a <= 7'h42; a++) op(1, 0, a[6:0], 8'($random(seed)));
    op(1, 0, 7'h7f, 8'hff);
    for (int a = 7'h10; a <= 7'h42; a++) op(0, 1, a[6:0], 8'h00);
    op(0, 1, 7'h7f, 8'h00);
    op(0, 0, 7'h00, 8'h00);
    check_limits();
    // a reset in mid-run brings every written byte back to its reset value
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    reset_shadow();
    for (int a = 7'h15; a <= 7'h3c; a++) op(0, 1, a[6:0], 8'h00);
    op(0, 0, 7'h00, 8'h00);
    check_limits();
    // single byte writes leave the other byte of each threshold alone
    op(1, 0, 7'h26, 8'haa);
    op(0, 1, 7'h26, 8'h00);
    op(1, 0, 7'h3b, 8'h5c);
    op(1, 0, 7'h16, 8'hff);
    op(0, 1, 7'h16, 8'h00);
    op(0, 1, 7'h17, 8'h00);
    op(0, 0, 7'h00, 8'h00);
    check_limits();
    repeat (3) @(posedge clk);
    if (exp_q.size() != 0) check(16'(exp_q.size()), 16'h0000);
    conclude();
  end
endmodule : alarm_threshold_regs_tb_top
`default_nettype wire
